// *** rtl/arlt_map.svh ***
`ifndef ARLT_MAP_SVH
`define ARLT_MAP_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ARLT_ADDR_CTRL 12'h000
`define ARLT_ADDR_CNT 12'h004
`define ARLT_ADDR_RLD 12'h008
`define ARLT_ADDR_CFG 12'h00C
`define ARLT_ADDR_IRQ_STAT 12'h010
`define ARLT_ADDR_IRQ_MASK 12'h014
// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define ARLT_B_HOVF 7
`define ARLT_B_LOVF 6
`define ARLT_B_LIEN 5
`define ARLT_B_CAPEN 4
`define ARLT_B_SPLIT 3
`define ARLT_B_RUN 2
`define ARLT_B_RO 1
`define ARLT_B_XCLK 0
// ----------------------------------------
// Config register bit positions
// ----------------------------------------
`define ARLT_B_TIE 0
`define ARLT_B_LFAST 1
`define ARLT_B_HFAST 2
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define ARLT_I_HOVF 0
`define ARLT_I_LOVF 1
`define ARLT_I_CAP 2
// ----------------------------------------
// Widths, reset values, timing
// ----------------------------------------
`define ARLT_NIRQ 3
`define ARLT_CTRL_RST 8'h00
`define ARLT_WORD_RST 16'h0000
`define ARLT_BYTE_MAX 8'hFF
`define ARLT_WORD_MAX 16'hFFFF
`define ARLT_DIV12_LAST 4'hB
`define ARLT_DIV8_LAST 3'h7
`define ARLT_HTRANS_NONSEQ 2'h2
`endif

// *** rtl/arlt_pkg.sv ***
package arlt_pkg;
  typedef struct packed {
    logic sys_tick;
    logic div12_tick;
    logic ext8_tick;
  } arlt_ticks_s;
  typedef enum logic [1:0] {
    ARLT_PH_IDLE,
    ARLT_PH_WRITE,
    ARLT_PH_READ
  } arlt_phase_e;
endpackage : arlt_pkg

// *** rtl/arlt_prescaler.sv ***
`include "arlt_map.svh"
module arlt_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_clk_in,
  output arlt_pkg::arlt_ticks_s ticks
);
  logic [3:0] div12_r;
  logic [2:0] ext8_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_rise;

  // ----------------------------------------
  // Synchronise external clock before edge detect
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_s3_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div12_r <= 4'h0;
    end else if (div12_r == `ARLT_DIV12_LAST) begin
      div12_r <= 4'h0;
    end else begin
      div12_r <= div12_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext8_r <= 3'h0;
    end else if (ext_rise) begin
      ext8_r <= ext8_r + 3'h1;
    end
  end

  assign ticks.sys_tick = 1'b1;
  assign ticks.div12_tick = (div12_r == `ARLT_DIV12_LAST);
  assign ticks.ext8_tick = ext_rise && (ext8_r == `ARLT_DIV8_LAST);
endmodule : arlt_prescaler

// *** rtl/arlt_lfo_edge.sv ***
module arlt_lfo_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lfo_in,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Two stages before the edge detector; the LFO is asynchronous
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= lfo_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign fall = s3_r & ~s2_r;
endmodule : arlt_lfo_edge

// *** rtl/arlt_timer.sv ***
// Implementation choices: the register offsets and register access over AHB-Lite.
`include "arlt_map.svh"
// Notes on behaviour
// - High flag sets when the upper count byte wraps FF to 00.
// - In 16-bit mode high flag sets when the full count wraps to zero.
// - With timer interrupts enabled, a set high flag raises the interrupt.
// - High flag only clears by software writing zero.
// - Low flag sets on low byte wrap in both modes.
// - Low flag stays set until software clears it.
// - Low flag interrupts only with low enable and timer enable both set; the masked low status event also interrupts without low enable.
// - Low interrupt enable bit: zero disables, one enables low interrupts; with zero the code still passes the masked low status event request.
// - Capture enabled: each LFO falling edge interrupts; zero disables capture.
// - Capture copies the 16-bit count into the reload registers.
// - Split select: zero gives one 16-bit counter, one gives two 8-bit.
// - Run bit gates counting; in split mode only the high byte.
// - Overflow reloads from the reload pair, or per byte in split mode.
// - Fast select picks system clock, else ext select picks /12 or ext/8.
// - Timer interrupt enable gates every request from this timer.
module arlt_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_clk_in,
  input wire logic lfo_in,
  output logic irq
);
  arlt_pkg::arlt_ticks_s ticks;
  arlt_pkg::arlt_phase_e phase_r;
  logic [11:0] addr_r;
  logic [7:0] ctrl_r;
  logic [2:0] cfg_r;
  logic [15:0] cnt_r;
  logic [15:0] rld_r;
  logic [`ARLT_NIRQ-1:0] istat_r;
  logic [`ARLT_NIRQ-1:0] imask_r;
  logic [31:0] rdata_nxt;
  logic lfo_fall;
  logic tick_lo;
  logic tick_hi;
  logic lo_wrap;
  logic hi_wrap;
  logic capture;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_rld;
  logic wr_cfg;
  logic wr_mask;
  logic rd_take;
  logic rd_istat;
  logic irq_nxt;

  function automatic logic pick_tick(input logic fast, input logic xclk,
                                     input arlt_pkg::arlt_ticks_s t);
    if (fast) begin
      pick_tick = t.sys_tick;
    end else if (xclk) begin
      pick_tick = t.ext8_tick;
    end else begin
      pick_tick = t.div12_tick;
    end
  endfunction : pick_tick

  // One data-phase write decode, shared by every writable register
  function automatic logic wr_hit(input arlt_pkg::arlt_phase_e ph, input logic [11:0] a,
                                  input logic [11:0] target);
    wr_hit = (ph == arlt_pkg::ARLT_PH_WRITE) && (a == target);
  endfunction : wr_hit

  arlt_prescaler u_pre (
    .clk(clk),
    .rst_n(rst_n),
    .ext_clk_in(ext_clk_in),
    .ticks(ticks)
  );

  arlt_lfo_edge u_lfo (
    .clk(clk),
    .rst_n(rst_n),
    .lfo_in(lfo_in),
    .fall(lfo_fall)
  );

  // ----------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= arlt_pkg::ARLT_PH_IDLE;
      addr_r <= 12'h000;
    end else if (hready) begin
      addr_r <= haddr;
      if (hsel && htrans == `ARLT_HTRANS_NONSEQ) begin
        phase_r <= hwrite ? arlt_pkg::ARLT_PH_WRITE : arlt_pkg::ARLT_PH_READ;
      end else begin
        phase_r <= arlt_pkg::ARLT_PH_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_ctrl = wr_hit(phase_r, addr_r, `ARLT_ADDR_CTRL);
  assign wr_cnt = wr_hit(phase_r, addr_r, `ARLT_ADDR_CNT);
  assign wr_rld = wr_hit(phase_r, addr_r, `ARLT_ADDR_RLD);
  assign wr_cfg = wr_hit(phase_r, addr_r, `ARLT_ADDR_CFG);
  assign wr_mask = wr_hit(phase_r, addr_r, `ARLT_ADDR_IRQ_MASK);

  // Read data is decoded in the address phase so hrdata is a flop
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (haddr)
      `ARLT_ADDR_CTRL: rdata_nxt = {24'h000000, ctrl_r};
      `ARLT_ADDR_CNT: rdata_nxt = {16'h0000, cnt_r};
      `ARLT_ADDR_RLD: rdata_nxt = {16'h0000, rld_r};
      `ARLT_ADDR_CFG: rdata_nxt = {29'h0000000, cfg_r};
      `ARLT_ADDR_IRQ_STAT: rdata_nxt = {29'h0000000, istat_r};
      `ARLT_ADDR_IRQ_MASK: rdata_nxt = {29'h0000000, imask_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // A read is taken at its address phase, so status clears as its value is latched
  assign rd_take = hready && hsel && (htrans == `ARLT_HTRANS_NONSEQ) && !hwrite;
  assign rd_istat = rd_take && (haddr == `ARLT_ADDR_IRQ_STAT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  assign tick_lo = pick_tick(cfg_r[`ARLT_B_LFAST], ctrl_r[`ARLT_B_XCLK], ticks);
  assign tick_hi = pick_tick(cfg_r[`ARLT_B_HFAST], ctrl_r[`ARLT_B_XCLK], ticks);
  // Split: low runs always, high gated by run; 16-bit: whole count gated
  assign lo_wrap = (ctrl_r[`ARLT_B_SPLIT] || ctrl_r[`ARLT_B_RUN]) && tick_lo &&
                   (cnt_r[7:0] == `ARLT_BYTE_MAX);
  assign hi_wrap = ctrl_r[`ARLT_B_SPLIT] ?
                   (ctrl_r[`ARLT_B_RUN] && tick_hi && cnt_r[15:8] == `ARLT_BYTE_MAX) :
                   (ctrl_r[`ARLT_B_RUN] && tick_lo && cnt_r == `ARLT_WORD_MAX);
  assign capture = ctrl_r[`ARLT_B_CAPEN] && lfo_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= `ARLT_WORD_RST;
    end else if (wr_cnt) begin
      cnt_r <= hwdata[15:0];
    end else if (ctrl_r[`ARLT_B_SPLIT]) begin
      if (ctrl_r[`ARLT_B_RUN] && tick_hi) begin
        cnt_r[15:8] <= hi_wrap ? rld_r[15:8] : cnt_r[15:8] + 8'h01;
      end
      if (tick_lo) begin
        cnt_r[7:0] <= lo_wrap ? rld_r[7:0] : cnt_r[7:0] + 8'h01;
      end
    end else if (ctrl_r[`ARLT_B_RUN] && tick_lo) begin
      cnt_r <= hi_wrap ? rld_r : cnt_r + 16'h0001;
    end
  end

  // Capture beats a same-cycle software write of the reload pair
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rld_r <= `ARLT_WORD_RST;
    end else if (capture) begin
      rld_r <= cnt_r;
    end else if (wr_rld) begin
      rld_r <= hwdata[15:0];
    end
  end

  // ----------------------------------------
  // Control register and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `ARLT_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[`ARLT_B_LIEN] <= hwdata[`ARLT_B_LIEN];
        ctrl_r[`ARLT_B_CAPEN] <= hwdata[`ARLT_B_CAPEN];
        ctrl_r[`ARLT_B_SPLIT] <= hwdata[`ARLT_B_SPLIT];
        ctrl_r[`ARLT_B_RUN] <= hwdata[`ARLT_B_RUN];
        ctrl_r[`ARLT_B_XCLK] <= hwdata[`ARLT_B_XCLK];
      end
      ctrl_r[`ARLT_B_RO] <= 1'b0;
      // Hardware set wins over a same-cycle software clear
      if (hi_wrap) begin
        ctrl_r[`ARLT_B_HOVF] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[`ARLT_B_HOVF] <= hwdata[`ARLT_B_HOVF];
      end
      if (lo_wrap) begin
        ctrl_r[`ARLT_B_LOVF] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r[`ARLT_B_LOVF] <= hwdata[`ARLT_B_LOVF];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= 3'h0;
      imask_r <= 3'h0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= hwdata[2:0];
      end
      if (wr_mask) begin
        imask_r <= hwdata[`ARLT_NIRQ-1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt events: sticky, cleared by reading status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_r <= 3'h0;
    end else begin
      istat_r <= (rd_istat ? 3'h0 : istat_r) | {capture, lo_wrap, hi_wrap};
    end
  end

  // Flag-level requests, the unmasked capture event and the masked event summary, all under the timer enable
  assign irq_nxt = cfg_r[`ARLT_B_TIE] && (
                   ctrl_r[`ARLT_B_HOVF] ||
                   (ctrl_r[`ARLT_B_LIEN] && ctrl_r[`ARLT_B_LOVF]) ||
                   istat_r[`ARLT_I_CAP] ||
                   |(istat_r & imask_r));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // ----------------------------------------
  // Checks: bus and read-clear status
  // ----------------------------------------
  bus_okay_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> hreadyout && !hresp) else $error("slave not ready or not okay");

  stat_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_istat && !capture && !lo_wrap && !hi_wrap) |=> !(|istat_r))
    else $error("status not cleared by read");

  // ----------------------------------------
  // Checks: counting
  // ----------------------------------------
  full_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_r[`ARLT_B_SPLIT] && ctrl_r[`ARLT_B_RUN] && tick_lo &&
     cnt_r == `ARLT_WORD_MAX && !wr_cnt)
    |=> cnt_r == $past(rld_r) && ctrl_r[`ARLT_B_HOVF]) else $error("16-bit wrap wrong");

  full_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_r[`ARLT_B_SPLIT] && !ctrl_r[`ARLT_B_RUN] && !wr_cnt) |=> $stable(cnt_r))
    else $error("count moved while stopped");

  split_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_SPLIT] && !ctrl_r[`ARLT_B_RUN] && !wr_cnt)
    |=> cnt_r[15:8] == $past(cnt_r[15:8])) else $error("high byte ran while stopped");

  lo_runs_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_SPLIT] && tick_lo && !wr_cnt && cnt_r[7:0] != `ARLT_BYTE_MAX)
    |=> cnt_r[7:0] == $past(cnt_r[7:0]) + 8'h01) else $error("low byte did not count");

  lo_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_SPLIT] && lo_wrap && !wr_cnt) |=> cnt_r[7:0] == $past(rld_r[7:0]))
    else $error("low byte reload wrong");

  hi_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_SPLIT] && hi_wrap && !wr_cnt) |=> cnt_r[15:8] == $past(rld_r[15:8]))
    else $error("high byte reload wrong");

  fast_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_r[`ARLT_B_LFAST] && cfg_r[`ARLT_B_HFAST]) |-> (tick_lo && tick_hi))
    else $error("fast clock select gave no tick");

  capture_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture |=> rld_r == $past(cnt_r)) else $error("capture did not copy");

  capture_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_r[`ARLT_B_CAPEN] && !wr_rld) |=> $stable(rld_r))
    else $error("reload moved without capture");

  // ----------------------------------------
  // Checks: flags and interrupts
  // ----------------------------------------
  hi_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    hi_wrap |=> ctrl_r[`ARLT_B_HOVF]) else $error("high flag not set on wrap");

  lo_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    lo_wrap |=> ctrl_r[`ARLT_B_LOVF]) else $error("low flag not set on wrap");

  hi_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_HOVF] && !wr_ctrl) |=> ctrl_r[`ARLT_B_HOVF]) else $error("high cleared");

  lo_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_LOVF] && !wr_ctrl) |=> ctrl_r[`ARLT_B_LOVF]) else $error("low cleared");

  hi_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_r[`ARLT_B_HOVF] && cfg_r[`ARLT_B_TIE]) |=> irq) else $error("no high irq");

  lo_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_r[`ARLT_B_TIE] && ctrl_r[`ARLT_B_LIEN] && ctrl_r[`ARLT_B_LOVF]) |=> irq)
    else $error("no low irq");

  lo_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_r[`ARLT_B_LIEN] && !ctrl_r[`ARLT_B_HOVF] && !(|istat_r)) |=> !irq)
    else $error("low flag interrupted while disabled");

  cap_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (capture && cfg_r[`ARLT_B_TIE] && !wr_cfg) |=> ##1 irq)
    else $error("no capture irq");

  lo_irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_r[`ARLT_B_TIE] |=> !irq) else $error("irq without timer enable");

  ro_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 !ctrl_r[`ARLT_B_RO]) else $error("read-only bit set");
endmodule : arlt_timer

// *** verification/tb_top.sv ***
`include "arlt_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, ext_clk_in, lfo_in, irq_probe;
  logic dp_rd = 1'b0;
  logic hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v;
  logic [63:0] note;
  logic [63:0] rq[$];
  logic iq[$];
  int bad_count, n_compared, cyc;

  arlt_timer DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_clk_in(ext_clk_in), .lfo_in(lfo_in),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Verdict, timeout, monitor
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic void cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endfunction : cmp

  // Negedge sampling sees the settled values that the next rising edge takes
  always @(negedge clk) begin
    if (dp_rd && hreadyout === 1'b1) begin
      note = rq.pop_front();
      cmp(hrdata & note[63:32], note[31:0]);
    end
    if (irq_probe) begin
      cmp({31'h0, irq}, {31'h0, iq.pop_front()});
    end
    dp_rd = hsel && htrans == `ARLT_HTRANS_NONSEQ && !hwrite && hreadyout === 1'b1;
  end

  // ----------------------------------------
  // Bus and probe tasks
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wait_rdy();
    logic ok;
    do begin
      @(negedge clk);
      ok = hreadyout;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask : wait_rdy

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `ARLT_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  // Upper bits get noise: a register must ignore them
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    r = $urandom;
    bus(a, 1'b1, {r[31:16], d});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    rq.push_back({m, e});
    bus(a, 1'b0, $urandom);
  endtask : rd

  task automatic chk_irq(input logic e);
    idle(3);
    iq.push_back(e);
    irq_probe <= 1'b1;
    @(posedge clk);
    irq_probe <= 1'b0;
  endtask : chk_irq

  task automatic lfo_pulse();
    lfo_in <= 1'b1;
    idle(6);
    lfo_in <= 1'b0;
    idle(8);
  endtask : lfo_pulse

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, hsel, hwrite, ext_clk_in, lfo_in, irq_probe} = '0;
    haddr = 12'h000;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    void'($urandom(32'h5E84));
    idle(20);
    rst_n <= 1'b1;
    rd(`ARLT_ADDR_CTRL, 32'h0);
    rd(`ARLT_ADDR_CNT, 32'h0);
    wr(`ARLT_ADDR_CTRL, 16'h0002);
    rd(`ARLT_ADDR_CTRL, 32'h0);
    wr(12'h020, 16'hFFFF);
    rd(12'h020, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      wr(`ARLT_ADDR_RLD, v[15:0]);
      rd(`ARLT_ADDR_RLD, {16'h0, v[15:0]});
    end
    // 16-bit wrap, fast clock, timer interrupt enabled
    wr(`ARLT_ADDR_CFG, 16'h0007);
    wr(`ARLT_ADDR_RLD, 16'h1234);
    wr(`ARLT_ADDR_CNT, 16'hFFFF);
    wr(`ARLT_ADDR_CTRL, 16'h0004);
    idle(5);
    rd(`ARLT_ADDR_CTRL, 32'hC4);
    chk_irq(1'b1);
    wr(`ARLT_ADDR_CTRL, 16'h00C0);
    rd(`ARLT_ADDR_CNT, 32'h1200, 32'hFF00);
    idle(20);
    rd(`ARLT_ADDR_CTRL, 32'hC0);
    rd(`ARLT_ADDR_IRQ_STAT, 32'h3);
    rd(`ARLT_ADDR_IRQ_STAT, 32'h0);
    wr(`ARLT_ADDR_CTRL, 16'h0000);
    chk_irq(1'b0);
    // Split mode: high byte wraps, low byte keeps running after stop
    wr(`ARLT_ADDR_CNT, 16'hFF00);
    wr(`ARLT_ADDR_CTRL, 16'h0008);
    idle(4);
    rd(`ARLT_ADDR_CNT, 32'hFF00, 32'hFF00);
    rd(`ARLT_ADDR_CTRL, 32'h08);
    wr(`ARLT_ADDR_CTRL, 16'h000C);
    rd(`ARLT_ADDR_CTRL, 32'h8C);
    wr(`ARLT_ADDR_CTRL, 16'h0088);
    idle(300);
    rd(`ARLT_ADDR_CTRL, 32'hC8);
    wr(`ARLT_ADDR_CTRL, 16'h0048);
    chk_irq(1'b0);
    wr(`ARLT_ADDR_CTRL, 16'h0068);
    chk_irq(1'b1);
    wr(`ARLT_ADDR_CFG, 16'h0006);
    chk_irq(1'b0);
    wr(`ARLT_ADDR_CFG, 16'h0007);
    wr(`ARLT_ADDR_CTRL, 16'h0000);
    wr(`ARLT_ADDR_IRQ_MASK, 16'h0002);
    chk_irq(1'b1);
    rd(`ARLT_ADDR_IRQ_STAT, 32'h2, 32'h2);
    wr(`ARLT_ADDR_IRQ_MASK, 16'h0000);
    // Capture on a falling edge of the slow oscillator
    wr(`ARLT_ADDR_CTRL, 16'h0010);
    wr(`ARLT_ADDR_CNT, 16'h5A3C);
    lfo_pulse();
    rd(`ARLT_ADDR_RLD, 32'h5A3C);
    chk_irq(1'b1);
    rd(`ARLT_ADDR_IRQ_STAT, 32'h4, 32'h4);
    chk_irq(1'b0);
    wr(`ARLT_ADDR_CTRL, 16'h0000);
    wr(`ARLT_ADDR_CNT, 16'h1111);
    lfo_pulse();
    rd(`ARLT_ADDR_RLD, 32'h5A3C);
    // Slow clock sources: external divided by 8, then system divided by 12
    wr(`ARLT_ADDR_CFG, 16'h0001);
    wr(`ARLT_ADDR_CNT, 16'h0000);
    wr(`ARLT_ADDR_CTRL, 16'h0005);
    repeat (16) begin
      idle(3);
      ext_clk_in <= 1'b1;
      idle(3);
      ext_clk_in <= 1'b0;
    end
    idle(6);
    wr(`ARLT_ADDR_CTRL, 16'h0001);
    rd(`ARLT_ADDR_CNT, 32'h2);
    wr(`ARLT_ADDR_CNT, 16'h0000);
    wr(`ARLT_ADDR_CTRL, 16'h0004);
    idle(120);
    wr(`ARLT_ADDR_CTRL, 16'h0000);
    rd(`ARLT_ADDR_CNT, 32'h0, 32'hFFF0);
    idle(4);
    // Reset after the counter is stopped must bring reload and config back to zero
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    rd(`ARLT_ADDR_RLD, 32'h0);
    rd(`ARLT_ADDR_CFG, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
